// ---- hw/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
    parameter int width = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [width-1:0] pin_raw,
    output logic [width-1:0] pin_level
);
    typedef struct packed {
        logic [width-1:0] s1;
        logic [width-1:0] s2;
        logic [width-1:0] s3;
        logic [width-1:0] level;
    } sync_state_t;
    sync_state_t state_reg;
    sync_state_t state_next;

    initial begin
        if (width < 1) $error("pin_sync width must be positive");
    end

    // level changes once stages two and three agree
    always_comb begin
        state_next = state_reg;
        state_next.s1 = pin_raw;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int i = 0; i < width; i++) begin
            if (state_reg.s2[i] == state_reg.s3[i]) begin
                state_next.level[i] = state_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pin_level = state_reg.level;
endmodule : pin_sync

// ---- hw/timer_shared_io_port.sv ----
`timescale 1ns/1ps
module timer_shared_io_port (
    input wire logic clock,
    input wire logic resetn,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tsio_pkg::timer_ctrl_t timer_ctrl,
    input wire tsio_pkg::timer_out_t timer_out,
    output tsio_pkg::timer_in_t timer_in,
    output logic timers_init,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);
    import tsio_pkg::*;

    typedef struct packed {
        logic [7:0] direction;
        logic [7:0] data;
        logic [31:0] rdata;
        logic err;
    } port_state_t;

    port_state_t state_reg;
    port_state_t state_next;
    logic [7:0] pin_level;
    logic in_standby;
    logic [7:0] claim;
    logic [7:0] func_val;
    logic [7:0] read_val;
    logic access;
    logic hit_dir;
    logic hit_data;
    timer_ctrl_t ctrl;

    pin_sync #(
        .width(8)
    ) u_sync (
        .clock(clock),
        .resetn(resetn),
        .pin_raw(pin_in),
        .pin_level(pin_level)
    );

    assign in_standby = sw_standby | hw_standby;
    // standby resets the timers so they release the pins
    assign timers_init = in_standby;
    always_comb begin
        ctrl = timer_ctrl;
        if (in_standby) begin
            ctrl = '0;
        end
    end

    // pin ownership follows the timer selects and enables, which standby forces off
    always_comb begin
        claim = 8'h00;
        func_val = 8'h00;
        claim[pin_wave1] = |ctrl.wave1_select;
        func_val[pin_wave1] = timer_out.wave1;
        claim[pin_wave0] = |ctrl.wave0_select;
        func_val[pin_wave0] = timer_out.wave0;
        claim[pin_cmp_b] = ctrl.compare_b_output_enable;
        func_val[pin_cmp_b] = timer_out.compare_b;
        claim[pin_cmp_a] = ctrl.compare_a_output_enable;
        func_val[pin_cmp_a] = timer_out.compare_a;
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            // a claimed pin drives the timer output
            assign pin_oe[g] = claim[g] | state_reg.direction[g];
            assign pin_out[g] = claim[g] ? func_val[g] : state_reg.data[g];
            // output bits read the latch, input bits the pin
            assign read_val[g] = state_reg.direction[g] ?
                state_reg.data[g] : pin_level[g];
        end
    endgenerate

    // timer inputs follow pin levels regardless of direction
    always_comb begin
        timer_in = '0;
        timer_in.capture_in_a = pin_level[pin_cap_a];
        timer_in.capture_in_b = pin_level[pin_cap_b];
        timer_in.capture_in_c = pin_level[pin_wave0];
        timer_in.capture_in_d = pin_level[pin_cap_d];
        timer_in.small_timer1_clock_in = pin_level[pin_cap_d];
        timer_in.clock1_valid = ctrl.clock1_select >= small_clock_ext_lo;
        timer_in.free_timer_ext_clock = pin_level[pin_ext_clk];
        timer_in.free_clock_valid =
            ctrl.free_clock_select == free_clock_ext;
        timer_in.small_timer0_clock_in = pin_level[pin_ext_clk];
        timer_in.clock0_valid = ctrl.clock0_select >= small_clock_ext_lo;
        timer_in.small_timer1_reset_in = pin_level[pin_cmp_b];
        timer_in.reset1_valid =
            ctrl.clear1_select == counter_clear_ext;
        timer_in.small_timer0_reset_in = pin_level[pin_cap_b];
        timer_in.reset0_valid =
            ctrl.clear0_select == counter_clear_ext;
    end

    assign access = psel & penable;
    assign hit_dir = paddr == port_direction_addr;
    assign hit_data = paddr == port_output_data_addr;

    // single-cycle access phase; sw standby just holds state
    always_comb begin
        state_next = state_reg;
        if (psel && !penable) begin
            state_next.err = !(hit_dir || hit_data);
            state_next.rdata = 32'h0000_0000;
            if (!pwrite && hit_dir) begin
                state_next.rdata = {24'h00_0000, direction_read_value};
            end
            if (!pwrite && hit_data) begin
                state_next.rdata = {24'h00_0000, read_val};
            end
        end
        if (access && pwrite && pstrb[0]) begin
            if (hit_dir) begin
                state_next.direction = pwdata[7:0];
            end
            if (hit_data) begin
                state_next.data = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || hw_standby) begin
            state_reg.direction <= port_direction_reset;
            state_reg.data <= port_output_data_reset;
            state_reg.rdata <= 32'h0000_0000;
            state_reg.err <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pready = 1'b1;
    assign prdata = state_reg.rdata;
    assign pslverr = access & state_reg.err;

    a_standby_hold: assert property (@(posedge clock) disable iff (!resetn)
        sw_standby && !hw_standby && !access && $past(sw_standby) &&
        !$past(access && pwrite) |->
        $stable(state_reg.direction) && $stable(state_reg.data))
        else $error("port registers changed in software standby");
    a_hw_clear: assert property (@(posedge clock) disable iff (!resetn)
        $past(hw_standby) |-> state_reg.direction == 8'h00 &&
        state_reg.data == 8'h00 && pin_oe == 8'h00)
        else $error("hardware standby did not clear port");
    a_dir_read: assert property (@(posedge clock) disable iff (!resetn)
        psel && !penable && !pwrite && hit_dir && !hw_standby |=>
        prdata == 32'h0000_00ff)
        else $error("direction read not all ones");
    a_out_read: assert property (@(posedge clock) disable iff (!resetn)
        psel && !penable && !pwrite && hit_data && !hw_standby |=>
        (prdata[7:0] & $past(state_reg.direction)) ==
        ($past(state_reg.data) & $past(state_reg.direction)))
        else $error("output bit read not from latch");
    a_in_read: assert property (@(posedge clock) disable iff (!resetn)
        psel && !penable && !pwrite && hit_data && !hw_standby |=>
        (prdata[7:0] & ~$past(state_reg.direction)) ==
        ($past(pin_level) & ~$past(state_reg.direction)))
        else $error("input bit read not from pin");
    a_wave1_pin: assert property (@(posedge clock) disable iff (!resetn)
        !in_standby && |timer_ctrl.wave1_select |->
        pin_oe[7] && pin_out[7] == timer_out.wave1)
        else $error("pin 7 not carrying timer1 wave");
    a_cmp_b_pin: assert property (@(posedge clock) disable iff (!resetn)
        !in_standby && timer_ctrl.compare_b_output_enable |->
        pin_oe[6] && pin_out[6] == timer_out.compare_b)
        else $error("pin 6 not carrying compare b");
    a_standby_gp: assert property (@(posedge clock) disable iff (!resetn)
        sw_standby |-> pin_oe == state_reg.direction &&
        pin_out == state_reg.data)
        else $error("timer still owns pin in standby");
    a_reset1_src: assert property (@(posedge clock) disable iff (!resetn)
        timer_in.reset1_valid |-> !in_standby &&
        timer_ctrl.clear1_select == 2'b11)
        else $error("timer1 reset taken without clear select");

    // register writes land at the access edge
    a_dir_write: assert property (@(posedge clock) disable iff (!resetn)
        access && pwrite && pstrb[0] && hit_dir && !hw_standby |=>
        state_reg.direction == $past(pwdata[7:0]))
        else $error("direction write did not land");

    a_data_write: assert property (@(posedge clock) disable iff (!resetn)
        access && pwrite && pstrb[0] && hit_data && !hw_standby |=>
        state_reg.data == $past(pwdata[7:0]))
        else $error("data write did not land");

    a_no_strobe: assert property (@(posedge clock) disable iff (!resetn)
        access && pwrite && !pstrb[0] && !hw_standby |=>
        $stable(state_reg.direction) && $stable(state_reg.data))
        else $error("write without strobe changed a register");

    a_read_upper: assert property (@(posedge clock) disable iff (!resetn)
        $past(psel && !penable && !pwrite) |->
        prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    a_read_hold: assert property (@(posedge clock) disable iff (!resetn)
        !psel && !hw_standby |=>
        $stable(prdata))
        else $error("read data moved while idle");

    // unclaimed pins follow the port registers
    a_gp_oe: assert property (@(posedge clock) disable iff (!resetn)
        1'b1 |->
        (pin_oe & ~claim) == (state_reg.direction & ~claim))
        else $error("free pin direction not from register");

    a_gp_out: assert property (@(posedge clock) disable iff (!resetn)
        1'b1 |->
        (pin_out & ~claim) == (state_reg.data & ~claim))
        else $error("free pin level not from register");

    a_fixed_pins: assert property (@(posedge clock) disable iff (!resetn)
        1'b1 |-> pin_oe[5] == state_reg.direction[5] &&
        pin_oe[3:2] == state_reg.direction[3:2] &&
        pin_oe[0] == state_reg.direction[0])
        else $error("input-only timer pin was claimed");

    // timer outputs take their pins
    a_wave0_pin: assert property (@(posedge clock) disable iff (!resetn)
        !in_standby && |timer_ctrl.wave0_select |->
        pin_oe[4] && pin_out[4] == timer_out.wave0)
        else $error("pin 4 not carrying timer0 wave");

    a_cmp_a_pin: assert property (@(posedge clock) disable iff (!resetn)
        !in_standby && timer_ctrl.compare_a_output_enable |->
        pin_oe[1] && pin_out[1] == timer_out.compare_a)
        else $error("pin 1 not carrying compare a");

    a_wave1_free: assert property (@(posedge clock) disable iff (!resetn)
        !in_standby && !(|timer_ctrl.wave1_select) |->
        pin_oe[7] == state_reg.direction[7])
        else $error("pin 7 claimed with select zero");

    a_wave0_free: assert property (@(posedge clock) disable iff (!resetn)
        !in_standby && !(|timer_ctrl.wave0_select) |->
        pin_oe[4] == state_reg.direction[4])
        else $error("pin 4 claimed with select zero");

    a_cmp_b_free: assert property (@(posedge clock) disable iff (!resetn)
        !timer_ctrl.compare_b_output_enable |->
        pin_oe[6] == state_reg.direction[6])
        else $error("pin 6 claimed without enable");

    a_cmp_a_free: assert property (@(posedge clock) disable iff (!resetn)
        !timer_ctrl.compare_a_output_enable |->
        pin_oe[1] == state_reg.direction[1])
        else $error("pin 1 claimed without enable");

    // timer inputs watch the synchronised pins
    a_reset0_src: assert property (@(posedge clock) disable iff (!resetn)
        timer_in.reset0_valid |-> !in_standby &&
        timer_ctrl.clear0_select == 2'b11)
        else $error("timer0 reset taken without clear select");

    a_reset_pins: assert property (@(posedge clock) disable iff (!resetn)
        1'b1 |-> timer_in.small_timer1_reset_in == pin_level[6] &&
        timer_in.small_timer0_reset_in == pin_level[3])
        else $error("timer reset inputs on wrong pins");

    a_cap_pins: assert property (@(posedge clock) disable iff (!resetn)
        1'b1 |-> timer_in.capture_in_a == pin_level[2] &&
        timer_in.capture_in_b == pin_level[3] &&
        timer_in.capture_in_c == pin_level[4] &&
        timer_in.capture_in_d == pin_level[5])
        else $error("capture inputs not following pins");

    a_clock1_pin: assert property (@(posedge clock) disable iff (!resetn)
        1'b1 |->
        timer_in.small_timer1_clock_in == pin_level[5])
        else $error("timer1 clock not from pin 5");

    a_clock1_valid: assert property (@(posedge clock) disable iff (!resetn)
        timer_in.clock1_valid |->
        !in_standby)
        else $error("timer1 clock valid in standby");

    a_ext_clk_pin: assert property (@(posedge clock) disable iff (!resetn)
        1'b1 |-> timer_in.free_timer_ext_clock == pin_level[0] &&
        timer_in.small_timer0_clock_in == pin_level[0])
        else $error("external clocks not from pin 0");

    a_free_valid: assert property (@(posedge clock) disable iff (!resetn)
        1'b1 |-> timer_in.free_clock_valid == (!in_standby &&
        timer_ctrl.free_clock_select == 2'b11))
        else $error("free timer clock qualifier wrong");

    a_clock0_valid: assert property (@(posedge clock) disable iff (!resetn)
        timer_in.clock0_valid |->
        !in_standby)
        else $error("timer0 clock valid in standby");

    // standby and reset behaviour
    a_init_standby: assert property (@(posedge clock) disable iff (!resetn)
        1'b1 |->
        timers_init == (sw_standby || hw_standby))
        else $error("timer init not following standby");

    a_standby_qual: assert property (@(posedge clock) disable iff (!resetn)
        in_standby |-> !timer_in.reset0_valid &&
        !timer_in.reset1_valid && !timer_in.clock0_valid &&
        !timer_in.clock1_valid && !timer_in.free_clock_valid)
        else $error("timer input qualified in standby");

    a_sw_drive: assert property (@(posedge clock) disable iff (!resetn)
        sw_standby && !hw_standby |-> (pin_out & pin_oe) ==
        (state_reg.data & state_reg.direction))
        else $error("driven level lost in software standby");

    a_reset_clear: assert property (@(posedge clock) disable iff (!resetn)
        $past(!resetn) |-> state_reg.direction == 8'h00 &&
        state_reg.data == 8'h00)
        else $error("reset did not clear port registers");

    a_hw_oe: assert property (@(posedge clock) disable iff (!resetn)
        hw_standby && $past(hw_standby) |->
        pin_oe == 8'h00)
        else $error("pin driven in hardware standby");
endmodule : timer_shared_io_port

// ---- pkg/tsio_pkg.sv ----
// Behaviour
// - direction bit 1 drives pin, 0 inputs
// - direction register reads back all ones
// - reset and hardware standby clear both registers
// - software standby keeps registers and driven outputs
// - software standby returns pins to port control
// - output bits read stored data value
// - input bits read live pin level
// - bit 7 is timer1 wave when select nonzero
// - compare enables claim pins 6 and 1
// - timer resets from pins 6, 3 when clear=11
// - pin 5 feeds capture d, timer1 clock
// - pin 0 clocks free timer and timer0
// - pin assignment same in every mode
package tsio_pkg;
    localparam logic [15:0] port_direction_offset = 16'hffb9;
    localparam logic [15:0] port_output_data_offset = 16'hffbb;
    localparam logic [31:0] port_direction_addr = 32'h0003_fee4;
    localparam logic [31:0] port_output_data_addr = 32'h0003_feec;
    localparam logic [7:0] port_direction_reset = 8'h00;
    localparam logic [7:0] port_output_data_reset = 8'h00;
    localparam logic [7:0] direction_read_value = 8'hff;
    localparam int pin_wave1 = 7;
    localparam int pin_cmp_b = 6;
    localparam int pin_cap_d = 5;
    localparam int pin_wave0 = 4;
    localparam int pin_cap_b = 3;
    localparam int pin_cap_a = 2;
    localparam int pin_cmp_a = 1;
    localparam int pin_ext_clk = 0;
    localparam logic [1:0] counter_clear_ext = 2'b11;
    localparam logic [1:0] free_clock_ext = 2'b11;
    localparam logic [2:0] small_clock_ext_lo = 3'b101;

    typedef struct packed {
        logic [3:0] wave0_select;
        logic [3:0] wave1_select;
        logic [1:0] clear0_select;
        logic [1:0] clear1_select;
        logic [2:0] clock0_select;
        logic [2:0] clock1_select;
        logic [1:0] free_clock_select;
        logic compare_a_output_enable;
        logic compare_b_output_enable;
    } timer_ctrl_t;

    typedef struct packed {
        logic wave0;
        logic wave1;
        logic compare_a;
        logic compare_b;
    } timer_out_t;

    typedef struct packed {
        logic capture_in_a;
        logic capture_in_b;
        logic capture_in_c;
        logic capture_in_d;
        logic free_timer_ext_clock;
        logic free_clock_valid;
        logic small_timer0_reset_in;
        logic small_timer1_reset_in;
        logic small_timer0_clock_in;
        logic small_timer1_clock_in;
        logic reset0_valid;
        logic reset1_valid;
        logic clock0_valid;
        logic clock1_valid;
    } timer_in_t;
endpackage : tsio_pkg

// ---- tb/pin_board.sv ----
`timescale 1ns/1ps
module pin_board (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    // driven bits show the port's level, released bits the board's
    always_comb begin
        pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
    end
endmodule : pin_board

// ---- tb/timer_shared_io_port_bench.sv ----
`timescale 1ns/1ps
module timer_shared_io_port_bench;
    import tsio_pkg::*;
    logic clock, resetn, hw_standby, sw_standby, psel, penable, pwrite;
    logic pready, pslverr, timers_init, err;
    logic [31:0] paddr, pwdata, prdata, rd, r;
    logic [3:0] pstrb;
    logic [7:0] pin_in, pin_out, pin_oe, ext, dir, data;
    timer_ctrl_t tc;
    timer_out_t to;
    timer_in_t ti;
    int fail_count, check_count;

    timer_shared_io_port dut_u (.clock(clock), .resetn(resetn),
        .hw_standby(hw_standby), .sw_standby(sw_standby), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_ctrl(tc), .timer_out(to), .timer_in(ti),
        .timers_init(timers_init), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe));
    pin_board board_u (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext), .pin_in(pin_in));

    always #2 clock = ~clock;

    task automatic check(input string name, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test

    task automatic apb(input logic wr, input logic [31:0] a,
                       input logic [7:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            $display("BAD pready expected 1 seen %b", pready);
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    // claimed pins: 7 wave1, 6 compare b, 4 wave0, 1 compare a
    function automatic logic [15:0] model(logic [7:0] d, v,
                                          timer_ctrl_t c, timer_out_t t);
        logic [7:0] k, x;
        k = {|c.wave1_select, c.compare_b_output_enable, 1'b0,
             |c.wave0_select, 2'b00, c.compare_a_output_enable, 1'b0};
        x = {t.wave1, t.compare_b, 1'b0, t.wave0, 2'b00, t.compare_a, 1'b0};
        return {d | k, (v & ~k) | (x & k)};
    endfunction : model

    function automatic timer_in_t exp_in(logic [7:0] v, timer_ctrl_t c);
        return '{v[2], v[3], v[4], v[5], v[0],
                 c.free_clock_select == free_clock_ext, v[3], v[6], v[0],
                 v[5], c.clear0_select == counter_clear_ext,
                 c.clear1_select == counter_clear_ext,
                 c.clock0_select >= small_clock_ext_lo,
                 c.clock1_select >= small_clock_ext_lo};
    endfunction : exp_in

    task automatic step(input logic sw);
        timer_ctrl_t c;
        logic [15:0] m;
        logic [7:0] w;
        apb(1'b1, port_direction_addr, dir);
        apb(1'b1, port_output_data_addr, data);
        sw_standby <= sw;
        repeat (6) @(posedge clock);
        c = sw ? '0 : tc;
        m = model(dir, data, c, to);
        w = (m[7:0] & m[15:8]) | (ext & ~m[15:8]);
        check("oe", 32'(pin_oe), 32'(m[15:8]));
        check("out", 32'(pin_out & pin_oe), 32'(m[7:0] & m[15:8]));
        check("init", 32'(timers_init), 32'(sw));
        check("tin", 32'(ti), 32'(exp_in(w, c)));
        check("claim", 32'(ti.capture_in_c), 32'(w[4]));
        apb(1'b0, port_direction_addr, 8'h00);
        check("dir_rd", rd, 32'h0000_00ff);
        apb(1'b0, port_output_data_addr, 8'h00);
        check("dat_rd", rd, 32'((data & dir) | (w & ~dir)));
        sw_standby <= 1'b0;
    endtask : step

    initial begin
        clock = 0;
        resetn = 0;
        hw_standby = 0;
        sw_standby = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        tc = '0;
        to = '0;
        ext = 8'h00;
        fail_count = 0;
        check_count = 0;
        void'($urandom(18));
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        check("oe_rst", 32'(pin_oe), 32'h0000_0000);
        apb(1'b0, port_output_data_addr, 8'h00);
        check("rst_rd", rd, 32'h0000_0000);
        $display("test reset done");
        // odd passes outside standby give the timers the pins; one pass in four, always an odd one, is in standby
        for (int i = 0; i < 24; i++) begin
            r = $urandom;
            dir = r[7:0];
            data = r[15:8];
            ext <= r[23:16];
            r = $urandom;
            tc <= timer_ctrl_t'(r[21:0] & {22{i[0]}});
            to <= timer_out_t'(r[25:22]);
            step((i % 4) == 3);
        end
        $display("test random done");
        apb(1'b0, 32'h0000_0010, 8'h00);
        check("unm_err", 32'(err), 32'h0000_0001);
        check("unm_rd", rd, 32'h0000_0000);
        $display("test unmapped done");
        tc <= '0;
        ext <= 8'h00;
        hw_standby <= 1'b1;
        repeat (2) @(posedge clock);
        hw_standby <= 1'b0;
        repeat (6) @(posedge clock);
        check("oe_hws", 32'(pin_oe), 32'h0000_0000);
        apb(1'b0, port_output_data_addr, 8'h00);
        check("hws_rd", rd, 32'h0000_0000);
        $display("test hw standby done");
        finish_test();
    end
endmodule : timer_shared_io_port_bench
